// File: design/adc_lane_channel_map.v
// Lane mapping registers of the serialized converter output stage and the lane source selectors.
`timescale 1ns/1ps
`include "lane_map_defines.vh"

module adc_lane_channel_map
#(
  parameter DATA_W  = 12,
  // Source table for codes 1..15, four bits per code: bit [2:0] picks one of the
  // eight default lane streams. Default entries map code n to stream (n-1) mod 8.
  // Entry n-1 sits at bits [4n-1:4n-4]; the top nibble has no code and is unused.
  // Boards that route channels differently override this table, not the logic.
  parameter [63:0] SRC_TABLE = 64'h7654_3210_7654_3210
)
(
  input  wire                clk,
  input  wire                rstn,
  input  wire                reg_wr,
  input  wire                reg_rd,
  input  wire [7:0]          reg_addr,
  input  wire [15:0]         reg_wdata,
  output reg  [15:0]         reg_rdata,
  output reg                 reg_rvalid,
  input  wire                dual_lane_select,
  input  wire [8*DATA_W-1:0] lane_in,
  output reg  [8*DATA_W-1:0] lane_out,
  output reg  [7:0]          lane_active
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops so every register leaves reset on the clock.
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Every other process resets on this copy; rstn itself reaches only the two flip-flops.
  wire rst_n_int = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Mapping registers. All sixteen bits are stored so software reads back what it wrote.
  reg [15:0] lane_map_pairs_one_q;
  reg [15:0] lane_map_pairs_two_q;
  reg [15:0] lane_map_pair_three_b_q;
  reg [15:0] lane_map_pair_three_a_q;
  reg [15:0] lane_map_pairs_four_q;

  // Writes take effect at the clock edge that samples the strobe.
  // Writes to offsets without a register, such as the gap between the pair-2 and the
  // pair-3 registers, are dropped; only one offset can match, so the chain order is free.
  always @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      lane_map_pairs_one_q    <= `MAP_RESET_VALUE;
      lane_map_pairs_two_q    <= `MAP_RESET_VALUE;
      lane_map_pair_three_b_q <= `MAP_RESET_VALUE;
      lane_map_pair_three_a_q <= `MAP_RESET_VALUE;
      lane_map_pairs_four_q   <= `MAP_RESET_VALUE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_LANE_MAP_PAIRS_ONE)
        lane_map_pairs_one_q <= reg_wdata;
      else if (reg_addr == `ADDR_LANE_MAP_PAIRS_TWO)
        lane_map_pairs_two_q <= reg_wdata;
      else if (reg_addr == `ADDR_LANE_MAP_PAIR_THREE_B)
        lane_map_pair_three_b_q <= reg_wdata;
      else if (reg_addr == `ADDR_LANE_MAP_PAIR_THREE_A)
        lane_map_pair_three_a_q <= reg_wdata;
      else if (reg_addr == `ADDR_LANE_MAP_PAIRS_FOUR)
        lane_map_pairs_four_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle after the strobe; unmapped addresses read as zero.
  // The address is decoded combinationally and captured only on the strobe edge.
  reg [15:0] rdata_d;

  // Unmapped addresses fall through to the final branch and read as zero.
  always @*
  begin
    if (reg_addr == `ADDR_LANE_MAP_PAIRS_ONE)
      rdata_d = lane_map_pairs_one_q;
    else if (reg_addr == `ADDR_LANE_MAP_PAIRS_TWO)
      rdata_d = lane_map_pairs_two_q;
    else if (reg_addr == `ADDR_LANE_MAP_PAIR_THREE_B)
      rdata_d = lane_map_pair_three_b_q;
    else if (reg_addr == `ADDR_LANE_MAP_PAIR_THREE_A)
      rdata_d = lane_map_pair_three_a_q;
    else if (reg_addr == `ADDR_LANE_MAP_PAIRS_FOUR)
      rdata_d = lane_map_pairs_four_q;
    else
      rdata_d = 16'h0000;
  end

  // Read data holds until the next read so a slow host may collect it late; the valid
  // pulse marks the one cycle in which it is new.
  always @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register enables. Each enable gates only the fields of its own register, so the
  // two pair-3 registers are switched on and off independently of each other.
  wire en_one     = lane_map_pairs_one_q[`MAP_ENABLE_BIT];
  wire en_two     = lane_map_pairs_two_q[`MAP_ENABLE_BIT];
  wire en_three_b = lane_map_pair_three_b_q[`MAP_ENABLE_BIT];
  wire en_three_a = lane_map_pair_three_a_q[`MAP_ENABLE_BIT];
  wire en_four    = lane_map_pairs_four_q[`MAP_ENABLE_BIT];

  // Effective selects. A field counts only while its own register's enable is set,
  // otherwise it reads as the default code, so half-programmed maps never glitch lanes.
  // Software that writes the fields and the enable in one access switches over cleanly.
  wire [3:0] src_sel_pair_1a = en_one ? lane_map_pairs_one_q[`FLD_PAIR_1A_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_1b = en_one ? lane_map_pairs_one_q[`FLD_PAIR_1B_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_2a = en_two ? lane_map_pairs_two_q[`FLD_PAIR_2A_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_2b = en_two ? lane_map_pairs_two_q[`FLD_PAIR_2B_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_3a = en_three_a ? lane_map_pair_three_a_q[`FLD_PAIR_3A_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_3b = en_three_b ? lane_map_pair_three_b_q[`FLD_PAIR_3B_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_4a = en_four ? lane_map_pairs_four_q[`FLD_PAIR_4A_LO +: 4] : `SEL_DEFAULT;
  wire [3:0] src_sel_pair_4b = en_four ? lane_map_pairs_four_q[`FLD_PAIR_4B_LO +: 4] : `SEL_DEFAULT;

  // Lane order: index 0..7 = 1a,1b,2a,2b,3a,3b,4a,4b.
  wire [31:0] sel_all = {src_sel_pair_4b, src_sel_pair_4a, src_sel_pair_3b, src_sel_pair_3a,
                         src_sel_pair_2b, src_sel_pair_2a, src_sel_pair_1b, src_sel_pair_1a};

  ////////////////////////////////////////////////////////////////////////////////
  // Per-lane source mux and lane gating. The mux is combinational and one process
  // below registers every lane, so each output bit has a single driver.
  wire [8*DATA_W-1:0] lane_out_d;
  wire [7:0]          lane_active_d;

  // One loop pass per output lane, eight in all, indexed in the lane order above.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_lane
      // The lane's own stream index, used for code zero or a clear enable.
      localparam integer OWN_LANE = gi;

      // Per-lane decode signals.
      wire [3:0] code;
      wire [3:0] code_m1;
      wire [5:0] entry_lo;
      wire [3:0] entry;
      wire [2:0] src_idx;
      wire       active;

      // Code n reads table entry n-1; for code zero the entry is fetched but never used.
      assign code     = sel_all[4*gi +: 4];
      assign code_m1  = code - 4'h1;
      assign entry_lo = {code_m1, 2'b00};
      assign entry    = SRC_TABLE[entry_lo +: 4];
      // Bit 3 of an entry is spare, since only eight source streams exist.
      assign src_idx  = (code == `SEL_DEFAULT) ? OWN_LANE[2:0] : entry[2:0];
      // B lanes are odd indices and stay idle in one-lane operation.
      assign active   = (gi % 2 == 0) ? 1'b1 : dual_lane_select;

      // An idle lane drives zero, not a stale word that a receiver could take for data.
      // Any lane may take any stream, so two lanes can carry the same channel at once.
      assign lane_out_d[gi*DATA_W +: DATA_W] = active ? lane_in[src_idx*DATA_W +: DATA_W] : {DATA_W{1'b0}};
      assign lane_active_d[gi]               = active;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers. The receiver sees a new map or a new lane count one cycle after
  // the write or the select change, and only ever on a clock edge, never in between.
  always @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      lane_out    <= {8*DATA_W{1'b0}};
      lane_active <= 8'h00;
    end
    else
    begin
      lane_out    <= lane_out_d;
      lane_active <= lane_active_d;
    end
  end

endmodule

// File: design/lane_map_defines.vh
// Register offsets, field positions, reset values and lane codes of the lane channel map.
`ifndef LANE_MAP_DEFINES_VH
`define LANE_MAP_DEFINES_VH

`define ADDR_LANE_MAP_PAIRS_ONE    8'h50
`define ADDR_LANE_MAP_PAIRS_TWO    8'h51
`define ADDR_LANE_MAP_PAIR_THREE_B 8'h53
`define ADDR_LANE_MAP_PAIR_THREE_A 8'h54
`define ADDR_LANE_MAP_PAIRS_FOUR   8'h55

`define MAP_RESET_VALUE 16'h0000
`define MAP_ENABLE_BIT  15

// Field low bit positions; every field is four bits wide.
`define FLD_PAIR_1B_LO 4
`define FLD_PAIR_1A_LO 0
`define FLD_PAIR_2B_LO 8
`define FLD_PAIR_2A_LO 4
`define FLD_PAIR_3B_LO 8
`define FLD_PAIR_3A_LO 0
`define FLD_PAIR_4A_LO 4
`define FLD_PAIR_4B_LO 0

`define SEL_DEFAULT 4'h0

`endif

// File: test/lane_map_checker_sva.sv
// Port assertions for the lane channel map.
`timescale 1ns/1ps
module lane_map_checker
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        dual_lane_select,
  input wire logic [7:0]  lane_active
);
  // One clock domain, so one clock and one reset serve every check.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_read_answered:
    assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
  a_no_stray_rvalid:
    assert property (!reg_rd |=> !reg_rvalid) else $error("stray rvalid");
  a_rdata_holds:
    assert property ($changed(reg_rdata) |-> $past(reg_rd)) else $error("rdata moved");
  a_write_readback:
    assert property (reg_wr && reg_addr == 8'h50 ##1 reg_rd && !reg_wr && reg_addr == 8'h50
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
  a_unmapped_zero:
    assert property (reg_rd && !(reg_addr inside {8'h50, 8'h51, 8'h53, 8'h54, 8'h55})
      |=> reg_rdata == 16'h0000) else $error("unmapped read");
  a_b_lanes_off:
    assert property (!dual_lane_select |=> (lane_active & 8'haa) == 8'h00) else $error("B lane on");
  a_b_lanes_on:
    assert property (dual_lane_select |=> (lane_active & 8'haa) == 8'haa) else $error("B lane off");
  a_primary_lanes_on:
    assert property (rstn && $past(rstn) && $past(rstn, 2) |=> (lane_active & 8'h55) == 8'h55)
      else $error("A lane off");
  a_reset_clear:
    assert property ($rose(rstn) |-> lane_active == 8'h00 && !reg_rvalid ##1 lane_active == 8'h00)
      else $error("not clear after reset");
endmodule
bind adc_lane_channel_map lane_map_checker chk_u (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rvalid, .dual_lane_select, .lane_active);

// File: test/lane_source.sv
// Converter side model: a fresh word on every lane each cycle.
`timescale 1ns/1ps
module lane_source
#(parameter DATA_W = 12)
(
  input  wire logic           clk,
  output logic [8*DATA_W-1:0] lane_in
);
  logic [7:0] count_q = 8'h00;
  initial lane_in = '0;
  // Moving on the falling edge keeps words steady around the sampling edge.
  always @(negedge clk)
  begin
    count_q <= count_q + 8'h01;
    for (int i = 0; i < 8; i++) lane_in[i*DATA_W +: DATA_W] <= DATA_W'({count_q, i[3:0]});
  end
endmodule

// File: test/adc_lane_channel_map_bench.sv
// Self-checking bench for the lane channel map.
`timescale 1ns/1ps
module adc_lane_channel_map_bench;
  localparam W = 12;
  logic           clk = 1'b0;
  logic           rstn, reg_wr, reg_rd, reg_rvalid, dual_lane_select;
  logic [7:0]     reg_addr, lane_active;
  logic [15:0]    reg_wdata, reg_rdata, shadow [8];
  logic [8*W-1:0] lane_in, lane_out, prev;
  int             err_count, comparisons;
  logic [7:0]     addr [5] = '{8'h50, 8'h51, 8'h53, 8'h54, 8'h55};
  logic [15:0]    data [5] = '{16'hff72, 16'hf34a, 16'hf5ff, 16'hfff6, 16'hff81};
  int             ri [8] = '{0, 0, 1, 1, 4, 3, 5, 5};
  int             lo [8] = '{0, 4, 4, 8, 0, 8, 4, 0};
  always #20 clk = ~clk;
  adc_lane_channel_map #(.DATA_W(W)) dut_u (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .dual_lane_select, .lane_in, .lane_out, .lane_active);
  lane_source #(.DATA_W(W)) src_u (.clk, .lane_in);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  // Each access is a one-cycle strobe; the shadow is what the host stored.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #1 reg_wr = 1'b0;
    shadow[a[2:0]] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) #1 reg_rd = 1'b0;
    check({15'h0, reg_rvalid}, 16'h0001);
    check(reg_rdata, exp);
  endtask
  // Disabled or zero codes keep a lane's own stream; B lanes idle in one-lane mode.
  task automatic lanes;
    int s;
    logic [3:0] c;
    // The source moves on the falling edge; the word taken here is what the next
    // rising edge registers.
    @(negedge clk) #1 prev = lane_in;
    @(posedge clk) #1;
    for (int i = 0; i < 8; i++)
    begin
      c = shadow[ri[i]][lo[i] +: 4];
      s = (shadow[ri[i]][15] && c != 4'h0) ? (c - 1) % 8 : i;
      check(16'(lane_out[i*W +: W]), (i % 2 && !dual_lane_select) ? 16'h0000 : 16'(prev[s*W +: W]));
    end
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, dual_lane_select} = '0;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // An idle cycle between two like strobes keeps one from being lowered and raised at once.
    foreach (addr[i])
    begin
      rd(addr[i], 16'h0000);
      @(posedge clk) #1;
    end
    wr(8'h52, 16'hffff);
    rd(8'h52, 16'h0000);
    lanes;
    foreach (addr[i])
    begin
      wr(addr[i], data[i]);
      rd(addr[i], data[i]);
    end
    dual_lane_select = 1'b1;
    lanes;
    dual_lane_select = 1'b0;
    lanes;
    foreach (addr[i])
    begin
      wr(addr[i], data[i] & 16'h7fff);
      @(posedge clk) #1;
    end
    lanes;
    // A reset in mid-run must clear registers that hold programmed fields and an enable.
    wr(8'h50, data[0]);
    rstn = 1'b0;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    foreach (addr[i])
    begin
      rd(addr[i], 16'h0000);
      @(posedge clk) #1;
    end
    lanes;
    results;
  end
  // Guard against a hang.
  initial
  begin
    #200us;
    err_count++;
    results;
  end
endmodule
